// file: core/ucesd_top.sv
// Purpose: event select decode and counter for the cache and home-logic monitor
// Assumes: all event inputs come from logic on clk, so none are synchronised
// Notes: decode is registered, the counter adds one cycle later
`timescale 1ns/100ps
`include "ucesd_map.svh"
module ucesd_top #(
	parameter int CNT_W = 48,
	parameter int ENTRIES = 32,
	parameter int INC_W = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire ucesd_pkg::ucesd_sel_t sel,
	input wire logic count_en,
	input wire logic count_clear,
	input wire logic fill_valid,
	input wire ucesd_pkg::ucesd_line_t fill_state,
	input wire logic victim_valid,
	input wire ucesd_pkg::ucesd_victim_t victim_state,
	input wire ucesd_pkg::ucesd_snoop_t snoop,
	input wire ucesd_pkg::ucesd_hreq_t hreq,
	input wire ucesd_pkg::ucesd_trk_t trk_full,
	input wire ucesd_pkg::ucesd_trk_t trk_busy,
	input wire logic [ENTRIES-1:0] io_rd_valid,
	input wire logic [ENTRIES-1:0] remote_rd_valid,
	input wire logic [ENTRIES-1:0] loc_rd_valid,
	output logic [CNT_W-1:0] count_r,
	output logic overflow_r,
	output logic hit_r
);
	logic [INC_W-1:0] inc_nxt;
	logic [INC_W-1:0] inc_r;
	logic snoop_hit;
	logic fill_hit;
	logic victim_hit;
	logic [`UCESD_HREQ_W-1:0] hreq_sel;
	logic [`UCESD_TRK_N-1:0] full_sel;
	logic [`UCESD_TRK_N-1:0] busy_sel;
	logic [INC_W-1:0] occ_cnt [`UCESD_TRK_N];
	logic [ENTRIES-1:0] trk_rd_valid [`UCESD_TRK_N];
	logic [CNT_W:0] sum;

	function automatic logic [INC_W-1:0] ucesd_ones(input logic [7:0] v);
		logic [INC_W-1:0] n;
		n = '0;
		for (int k = 0; k < 8; k++) begin
			n = n + INC_W'(v[k]);
		end
		return n;
	endfunction : ucesd_ones

	ucesd_snoop_match u_snoop (
		.snoop(snoop),
		.umask(sel.umask),
		.filter(sel.filter),
		.hit(snoop_hit)
	);

	assign trk_rd_valid[`UCESD_TRK_IO] = io_rd_valid;
	assign trk_rd_valid[`UCESD_TRK_REMOTE] = remote_rd_valid;
	assign trk_rd_valid[`UCESD_TRK_LOC] = loc_rd_valid;

	// Each tracker is summed only when its unit-mask bit selects it
	for (genvar t = 0; t < `UCESD_TRK_N; t++) begin : g_occ
		ucesd_occ_count #(
			.ENTRIES(ENTRIES),
			.OUT_W(INC_W)
		) u_occ (
			.enable(sel.umask[t]),
			.rd_valid(trk_rd_valid[t]),
			.count(occ_cnt[t])
		);
	end

	// Mask bits line up with the one-hot state vectors, so a multi-bit
	// mask such as the any-state value is a plain OR of its members
	assign fill_hit = fill_valid && |(sel.umask[`UCESD_FILL_W-1:0] & fill_state);
	assign victim_hit = victim_valid &&
		|(sel.umask[`UCESD_VICT_W-1:0] & victim_state);
	assign hreq_sel = sel.umask[`UCESD_HREQ_W-1:0] & hreq;
	assign full_sel = sel.umask[`UCESD_TRK_N-1:0] & trk_full;
	assign busy_sel = sel.umask[`UCESD_TRK_N-1:0] & trk_busy;

	// Unknown event numbers decode to nothing rather than a stale event
	always_comb begin
		inc_nxt = '0;
		unique case (sel.event_num)
			`UCESD_EV_FILL: inc_nxt = INC_W'(fill_hit);
			`UCESD_EV_VICTIM: inc_nxt = INC_W'(victim_hit);
			`UCESD_EV_SNOOP: inc_nxt = INC_W'(snoop_hit);
			`UCESD_EV_HREQ: inc_nxt = ucesd_ones(8'(hreq_sel));
			`UCESD_EV_FULL: inc_nxt = ucesd_ones(8'(full_sel));
			`UCESD_EV_BUSY: inc_nxt = ucesd_ones(8'(busy_sel));
			`UCESD_EV_OCC: inc_nxt = occ_cnt[`UCESD_TRK_IO] + occ_cnt[`UCESD_TRK_REMOTE] +
				occ_cnt[`UCESD_TRK_LOC];
			default: inc_nxt = '0;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			inc_r <= '0;
		end else begin
			inc_r <= inc_nxt;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hit_r <= 1'b0;
		end else begin
			hit_r <= (inc_nxt != '0);
		end
	end

	assign sum = {1'b0, count_r} + (CNT_W+1)'(inc_r);

	// Clear takes priority over counting on the counter itself
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count_r <= '0;
		end else if (count_clear) begin
			count_r <= '0;
		end else if (count_en) begin
			count_r <= sum[CNT_W-1:0];
		end
	end

	// Clear blocks the add, so a wrap can never meet a clear in one cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			overflow_r <= 1'b0;
		end else begin
			overflow_r <= (count_en && !count_clear && sum[CNT_W]) ||
				(overflow_r && !count_clear);
		end
	end

	// Checks
	logic ev_known;
	logic [INC_W-1:0] io_occ_ref;
	logic snoop_prior_ref;
	logic [INC_W-1:0] remote_occ_ref;
	logic [INC_W-1:0] loc_occ_ref;

	assign ev_known = (sel.event_num == `UCESD_EV_FILL) || (sel.event_num == `UCESD_EV_VICTIM) ||
		(sel.event_num == `UCESD_EV_SNOOP) || (sel.event_num == `UCESD_EV_HREQ) ||
		(sel.event_num == `UCESD_EV_FULL) || (sel.event_num == `UCESD_EV_BUSY) ||
		(sel.event_num == `UCESD_EV_OCC);
	assign io_occ_ref = INC_W'($countones(io_rd_valid));
	// Reference terms written from the rules, apart from the decode above
	assign snoop_prior_ref = |(sel.filter & snoop.prior);
	assign remote_occ_ref = INC_W'($countones(remote_rd_valid));
	assign loc_occ_ref = INC_W'($countones(loc_rd_valid));

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	fill_mod_a: assert property (
		(sel.event_num == `UCESD_EV_FILL) && sel.umask[0] && fill_valid && fill_state.m
		|=> inc_r == INC_W'(1) && hit_r)
		else $error("modified fill not counted");

	fill_miss_a: assert property (
		(sel.event_num == `UCESD_EV_FILL) && !(|(sel.umask[`UCESD_FILL_W-1:0] & fill_state))
		|=> inc_r == '0)
		else $error("fill counted in unselected state");

	fill_any_a: assert property (
		(sel.event_num == `UCESD_EV_FILL) && (sel.umask == `UCESD_UM_FILL_ANY) && fill_valid &&
		$onehot(fill_state) |=> inc_r == INC_W'(1))
		else $error("any-state fill not counted");

	victim_mod_a: assert property (
		(sel.event_num == `UCESD_EV_VICTIM) && sel.umask[0] && victim_valid && victim_state.m
		|=> inc_r == INC_W'(1))
		else $error("modified victim not counted");

	victim_inv_a: assert property (
		(sel.event_num == `UCESD_EV_VICTIM) && (sel.umask == `UCESD_UM_VICT_I) && victim_valid &&
		!victim_state.i |=> inc_r == '0)
		else $error("invalid-state victim mask counted another state");

	victim_any_a: assert property (
		(sel.event_num == `UCESD_EV_VICTIM) && (sel.umask == `UCESD_UM_VICT_ANY) && victim_valid &&
		$onehot(victim_state) |=> inc_r == INC_W'(1))
		else $error("any-state victim not counted");

	snoop_plain_a: assert property (
		(sel.event_num == `UCESD_EV_SNOOP) && sel.umask[0] && snoop.valid && snoop.to_shared
		|=> inc_r == INC_W'(1))
		else $error("snoop to shared not counted");

	snoop_filt_a: assert property (
		(sel.event_num == `UCESD_EV_SNOOP) && (sel.umask == `UCESD_UM_SNP_S_FILT) &&
		snoop.valid && snoop.to_shared |=> inc_r == INC_W'($past(snoop_prior_ref)))
		else $error("filtered snoop to shared miscounted");

	snoop_inv_filt_a: assert property (
		(sel.event_num == `UCESD_EV_SNOOP) && (sel.umask == `UCESD_UM_SNP_I_FILT) &&
		snoop.valid && snoop.to_invalid && !(|(sel.filter & snoop.prior)) |=> inc_r == '0)
		else $error("snoop to invalid counted outside filter");

	snoop_fwd_a: assert property (
		(sel.event_num == `UCESD_EV_SNOOP) && (sel.umask == `UCESD_UM_SNP_S_FILT) &&
		(sel.filter == `UCESD_FILT_FWD) && snoop.valid && snoop.to_shared && snoop.prior.f
		|=> inc_r == INC_W'(1))
		else $error("forward prior state snoop not counted");

	hreq_sum_a: assert property (
		(sel.event_num == `UCESD_EV_HREQ)
		|=> inc_r == INC_W'($countones($past(sel.umask[5:0]) & $past(hreq))))
		else $error("home request count mismatch");

	full_sum_a: assert property (
		(sel.event_num == `UCESD_EV_FULL)
		|=> inc_r == INC_W'($countones($past(sel.umask[2:0]) & $past(trk_full))))
		else $error("tracker full cycles mismatch");

	busy_sum_a: assert property (
		(sel.event_num == `UCESD_EV_BUSY)
		|=> inc_r == INC_W'($countones($past(sel.umask[2:0]) & $past(trk_busy))))
		else $error("tracker busy cycles mismatch");

	occ_io_a: assert property (
		(sel.event_num == `UCESD_EV_OCC) && (sel.umask == `UCESD_UM_TRK_IO)
		|=> inc_r == $past(io_occ_ref))
		else $error("occupancy does not match valid entries");

	unknown_ev_a: assert property (
		!ev_known |=> inc_r == '0 ##1 count_r == $past(count_r) || $past(count_clear))
		else $error("unknown event advanced counter");

	count_step_a: assert property (
		count_en && !count_clear |=> count_r == CNT_W'($past(count_r) + CNT_W'($past(inc_r))))
		else $error("counter did not add increment");

	fill_excl_a: assert property (
		(sel.event_num == `UCESD_EV_FILL) && (sel.umask == `UCESD_UM_FILL_E) && fill_valid &&
		fill_state.e |=> inc_r == INC_W'(1))
		else $error("exclusive fill not counted");

	fill_fwd_a: assert property (
		(sel.event_num == `UCESD_EV_FILL) && (sel.umask == `UCESD_UM_FILL_F) && fill_valid &&
		fill_state.f |=> inc_r == INC_W'(1))
		else $error("forward fill not counted");

	victim_excl_a: assert property (
		(sel.event_num == `UCESD_EV_VICTIM) && (sel.umask == `UCESD_UM_VICT_E) &&
		victim_valid && victim_state.e |=> inc_r == INC_W'(1))
		else $error("exclusive victim not counted");

	victim_fwd_a: assert property (
		(sel.event_num == `UCESD_EV_VICTIM) && (sel.umask == `UCESD_UM_VICT_F) &&
		victim_valid && victim_state.f |=> inc_r == INC_W'(1))
		else $error("forward victim not counted");

	snoop_inval_a: assert property (
		(sel.event_num == `UCESD_EV_SNOOP) && (sel.umask == `UCESD_UM_SNP_I_ANY) &&
		snoop.valid && snoop.to_invalid |=> inc_r == INC_W'(1))
		else $error("snoop to invalid not counted");

	snoop_idle_a: assert property (
		(sel.event_num == `UCESD_EV_SNOOP) && !snoop.valid |=> inc_r == '0)
		else $error("idle snoop slot counted");

	hreq_remote_a: assert property (
		(sel.event_num == `UCESD_EV_HREQ) && (sel.umask == `UCESD_UM_REQ_REMOTE_RD)
		|=> inc_r == INC_W'($past(hreq.remote_rd)))
		else $error("remote read request miscounted");

	hreq_local_a: assert property (
		(sel.event_num == `UCESD_EV_HREQ) && (sel.umask == `UCESD_UM_REQ_LOC_WR)
		|=> inc_r == INC_W'($past(hreq.loc_wr)))
		else $error("local write request miscounted");

	occ_remote_a: assert property (
		(sel.event_num == `UCESD_EV_OCC) && (sel.umask == `UCESD_UM_TRK_REMOTE)
		|=> inc_r == $past(remote_occ_ref))
		else $error("remote tracker occupancy mismatch");

	occ_loc_a: assert property (
		(sel.event_num == `UCESD_EV_OCC) && (sel.umask == `UCESD_UM_TRK_LOC)
		|=> inc_r == $past(loc_occ_ref))
		else $error("local tracker occupancy mismatch");

	hold_still_a: assert property (
		!count_en && !count_clear |=> count_r == $past(count_r))
		else $error("counter moved while disabled");

	clear_zero_a: assert property (
		count_clear |=> count_r == '0 && !overflow_r)
		else $error("clear left counter or flag set");

	// A wrap is seen as the add passing the all-ones value of the counter
	wrap_set_a: assert property (
		count_en && !count_clear && (count_r > {CNT_W{1'b1}} - CNT_W'(inc_r))
		|=> overflow_r)
		else $error("counter wrap did not set flag");

	flag_sticky_a: assert property (
		overflow_r && !count_clear |=> overflow_r)
		else $error("wrap flag dropped without clear");

	fill_cov: cover property ((sel.event_num == `UCESD_EV_FILL) && fill_valid ##1 inc_r != '0);
	snoop_cov: cover property ((sel.event_num == `UCESD_EV_SNOOP) && snoop_hit ##1 hit_r);
	occ_cov: cover property ((sel.event_num == `UCESD_EV_OCC) ##1 inc_r > INC_W'(1));
	wrap_cov: cover property (!overflow_r ##1 overflow_r);
	hreq_cov: cover property ((sel.event_num == `UCESD_EV_HREQ) ##1 inc_r > INC_W'(2));
endmodule : ucesd_top

// file: core/ucesd_map.svh
// Purpose: constants for the uncore event select decode block
// Assumes: event numbers and unit masks are eight bits wide
// Notes: Function list below
// Function
// - Fill event mask 01 counts modified fills
// - Fill masks 02/04/08 count exclusive, shared, forward
// - Fill mask 0F counts fills in any state
// - Victim mask 01 counts modified evictions
// - Victim masks 02/04/08/10 count E,S,I,F evictions
// - Victim mask 1F counts every eviction
// - Snoop masks 01/02 count to shared/invalid
// - Snoop mask 04 filters shared moves by prior state
// - Snoop mask 08 filters invalid moves by prior state
// - Filter value 8 selects forward prior state
// - Request masks 01/02 count I/O hub reads/writes
// - Request masks 04/08 count remote reads/writes
// - Request masks 10/20 count local reads/writes
// - Full event adds one per full tracker cycle
// - Busy event adds one per busy tracker cycle
// - Occupancy event accumulates selected tracker read occupancy
`ifndef UCESD_MAP_SVH
`define UCESD_MAP_SVH
`define UCESD_EV_FILL 8'h0a
`define UCESD_EV_VICTIM 8'h0b
`define UCESD_EV_SNOOP 8'h0c
`define UCESD_EV_HREQ 8'h20
`define UCESD_EV_FULL 8'h21
`define UCESD_EV_BUSY 8'h22
`define UCESD_EV_OCC 8'h23
`define UCESD_UM_SNP_S_BIT 0
`define UCESD_UM_SNP_I_BIT 1
`define UCESD_UM_SNP_S_PRIOR_BIT 2
`define UCESD_UM_SNP_I_PRIOR_BIT 3
`define UCESD_UM_FILL_ANY 8'h0f
`define UCESD_UM_VICT_ANY 8'h1f
`define UCESD_UM_SNP_S_FILT 8'h04
`define UCESD_UM_SNP_I_FILT 8'h08
`define UCESD_UM_TRK_IO 8'h01
`define UCESD_UM_TRK_REMOTE 8'h02
`define UCESD_UM_TRK_LOC 8'h04
`define UCESD_UM_FILL_E 8'h02
`define UCESD_UM_FILL_F 8'h08
`define UCESD_UM_VICT_E 8'h02
`define UCESD_UM_VICT_I 8'h08
`define UCESD_UM_VICT_F 8'h10
`define UCESD_UM_SNP_I_ANY 8'h02
`define UCESD_UM_REQ_REMOTE_RD 8'h04
`define UCESD_UM_REQ_LOC_WR 8'h20
`define UCESD_FILL_W 4
`define UCESD_VICT_W 5
`define UCESD_HREQ_W 6
`define UCESD_TRK_N 3
`define UCESD_TRK_IO 0
`define UCESD_TRK_REMOTE 1
`define UCESD_TRK_LOC 2
`define UCESD_FILT_FWD 4'h8
`endif

// file: core/ucesd_pkg.sv
// Purpose: shared types for the uncore event select decode block
// Assumes: one-hot coherence state vectors from the cache logic
// Notes: field order puts each state on its unit-mask bit
package ucesd_pkg;
	// Bit order m,e,s,f from LSB matches fill mask and snoop filter
	typedef struct packed {
		logic f;
		logic s;
		logic e;
		logic m;
	} ucesd_line_t;

	typedef struct packed {
		logic f;
		logic i;
		logic s;
		logic e;
		logic m;
	} ucesd_victim_t;

	typedef struct packed {
		logic loc_wr;
		logic loc_rd;
		logic remote_wr;
		logic remote_rd;
		logic io_wr;
		logic io_rd;
	} ucesd_hreq_t;

	typedef struct packed {
		logic loc;
		logic remote;
		logic io;
	} ucesd_trk_t;

	typedef struct packed {
		logic [7:0] event_num;
		logic [7:0] umask;
		ucesd_line_t filter;
	} ucesd_sel_t;

	typedef struct packed {
		logic valid;
		logic to_shared;
		logic to_invalid;
		ucesd_line_t prior;
	} ucesd_snoop_t;
endpackage : ucesd_pkg

// file: core/ucesd_snoop_match.sv
// Purpose: decide whether one remote snoop matches the snoop unit mask
// Assumes: prior state is one-hot when a snoop is valid
// Notes: combinational, result consumed in the same cycle
`timescale 1ns/100ps
`include "ucesd_map.svh"
module ucesd_snoop_match (
	input wire ucesd_pkg::ucesd_snoop_t snoop,
	input wire logic [7:0] umask,
	input wire ucesd_pkg::ucesd_line_t filter,
	output logic hit
);
	logic prior_ok;

	// Forward prior state is filter bit 3, value 8
	assign prior_ok = |(filter & snoop.prior);

	// One snoop counts once even when several mask bits match it
	always_comb begin
		hit = 1'b0;
		if (snoop.valid) begin
			hit = (umask[`UCESD_UM_SNP_S_BIT] && snoop.to_shared) ||
				(umask[`UCESD_UM_SNP_I_BIT] && snoop.to_invalid) ||
				(umask[`UCESD_UM_SNP_S_PRIOR_BIT] && snoop.to_shared && prior_ok) ||
				(umask[`UCESD_UM_SNP_I_PRIOR_BIT] && snoop.to_invalid && prior_ok);
		end
	end
endmodule : ucesd_snoop_match

// file: core/ucesd_occ_count.sv
// Purpose: count the valid read entries of one home tracker
// Assumes: one valid bit per tracker entry
// Notes: yields zero when the tracker is not selected
`timescale 1ns/100ps
module ucesd_occ_count #(
	parameter int ENTRIES = 32,
	parameter int OUT_W = 8
) (
	input wire logic enable,
	input wire logic [ENTRIES-1:0] rd_valid,
	output logic [OUT_W-1:0] count
);
	logic [OUT_W-1:0] acc;

	always_comb begin
		acc = '0;
		for (int k = 0; k < ENTRIES; k++) begin
			acc = acc + OUT_W'(rd_valid[k]);
		end
		count = enable ? acc : '0;
	end
endmodule : ucesd_occ_count

// file: verification/ucesd_far_model.sv
// Purpose: cache and home tracker logic feeding event pulses and levels
// Assumes: rnd is a fresh random word each cycle from the bench
// Notes: states stay one-hot; a quiet draw idles every pulse
`timescale 1ns/100ps
module ucesd_far_model #(
	parameter int ENTRIES = 32
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [31:0] rnd,
	output ucesd_pkg::ucesd_line_t fill_state,
	output logic fill_valid,
	output logic victim_valid,
	output ucesd_pkg::ucesd_victim_t victim_state,
	output ucesd_pkg::ucesd_snoop_t snoop,
	output ucesd_pkg::ucesd_hreq_t hreq,
	output ucesd_pkg::ucesd_trk_t trk_full,
	output ucesd_pkg::ucesd_trk_t trk_busy,
	output logic [ENTRIES-1:0] io_rd_valid,
	output logic [ENTRIES-1:0] remote_rd_valid,
	output logic [ENTRIES-1:0] loc_rd_valid
);
	logic quiet;
	assign quiet = rnd[31:30] == 2'h0;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			{fill_valid, victim_valid, snoop, hreq} <= '0;
		end else begin
			fill_valid <= rnd[9] & !quiet;
			victim_valid <= rnd[25] & !quiet;
			snoop <= {rnd[15] & !quiet, rnd[16], !rnd[16], 4'h1 << rnd[18:17]};
			hreq <= quiet ? 6'h00 : rnd[24:19];
		end
	end
	// Full implies busy, as a real tracker would report
	always_ff @(posedge clk) begin
		fill_state <= 4'h1 << rnd[11:10];
		victim_state <= 5'h01 << (rnd[14:12] % 5);
		trk_full <= rnd[2:0] & rnd[5:3];
		trk_busy <= (rnd[2:0] & rnd[5:3]) | rnd[8:6];
		io_rd_valid <= rnd;
		remote_rd_valid <= {rnd[15:0], rnd[31:16]};
		loc_rd_valid <= rnd & {rnd[7:0], rnd[31:8]};
	end
endmodule : ucesd_far_model

// file: verification/ucesd_tb_top.sv
// Purpose: self-checking bench for the event select decode block
// Assumes: counter shortened so that wraps happen within the run
// Notes: a reference model tracks increment, hit and count every cycle
`timescale 1ns/100ps
module ucesd_tb_top;
	localparam int CW = 12;
	logic clk = 0;
	logic rst, count_en, count_clear, exp_hit, exp_ov;
	logic [31:0] rnd, lfsr;
	logic [CW:0] exp_sum;
	int unsigned exp_inc;
	int bad_count = 0;
	int checks_done = 0;
	ucesd_pkg::ucesd_sel_t sel;
	ucesd_pkg::ucesd_line_t fill_state;
	ucesd_pkg::ucesd_victim_t victim_state;
	ucesd_pkg::ucesd_snoop_t snoop;
	ucesd_pkg::ucesd_hreq_t hreq;
	ucesd_pkg::ucesd_trk_t trk_full, trk_busy;
	logic fill_valid, victim_valid, hit_r, overflow_r;
	logic [31:0] io_rd_valid, remote_rd_valid, loc_rd_valid;
	logic [CW-1:0] count_r;
	logic [7:0] ev_tab [8] = '{8'h0a, 8'h0b, 8'h0c, 8'h20, 8'h21, 8'h22, 8'h23, 8'h55};
	logic [7:0] um_tab [4] = '{8'h0f, 8'h1f, 8'h3f, 8'h07};
	always #10 clk = ~clk;
	ucesd_far_model i_ucesd_far_model (.clk(clk), .rst(rst), .rnd(rnd),
		.fill_state(fill_state), .fill_valid(fill_valid), .victim_valid(victim_valid),
		.victim_state(victim_state), .snoop(snoop), .hreq(hreq), .trk_full(trk_full),
		.trk_busy(trk_busy), .io_rd_valid(io_rd_valid), .remote_rd_valid(remote_rd_valid),
		.loc_rd_valid(loc_rd_valid));
	ucesd_top #(.CNT_W(CW), .ENTRIES(32), .INC_W(8)) i_ucesd_top (.clk(clk), .rst(rst),
		.sel(sel), .count_en(count_en), .count_clear(count_clear), .fill_valid(fill_valid),
		.fill_state(fill_state), .victim_valid(victim_valid), .victim_state(victim_state),
		.snoop(snoop), .hreq(hreq), .trk_full(trk_full), .trk_busy(trk_busy),
		.io_rd_valid(io_rd_valid), .remote_rd_valid(remote_rd_valid),
		.loc_rd_valid(loc_rd_valid), .count_r(count_r), .overflow_r(overflow_r),
		.hit_r(hit_r));
	function automatic logic [31:0] lfsr_f(input logic [31:0] v);
		for (int i = 0; i < 32; i++) begin
			v = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
		end
		return v;
	endfunction : lfsr_f
	function automatic int unsigned inc_f();
		case (sel.event_num)
		8'h0a: return fill_valid & |(sel.umask[3:0] & fill_state);
		8'h0b: return victim_valid & |(sel.umask[4:0] & victim_state);
		8'h0c: return snoop.valid & (sel.umask[0] & snoop.to_shared
			| sel.umask[1] & snoop.to_invalid | (|(sel.filter & snoop.prior))
			& (sel.umask[2] & snoop.to_shared | sel.umask[3] & snoop.to_invalid));
		8'h20: return $countones(sel.umask[5:0] & hreq);
		8'h21: return $countones(sel.umask[2:0] & trk_full);
		8'h22: return $countones(sel.umask[2:0] & trk_busy);
		8'h23: return (sel.umask[0] ? $countones(io_rd_valid) : 0)
			+ (sel.umask[1] ? $countones(remote_rd_valid) : 0)
			+ (sel.umask[2] ? $countones(loc_rd_valid) : 0);
		default: return 0;
		endcase
	endfunction : inc_f
	task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
			bad_count++;
		end
	endtask : check
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : close_out
	// Reads inputs before this edge's updates land, just as the design samples them
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			{exp_inc, exp_hit, exp_sum, exp_ov} = '0;
		end else begin
			if (count_clear) begin
				{exp_sum, exp_ov} = '0;
			end else if (count_en) begin
				exp_sum = exp_sum[CW-1:0] + exp_inc;
				exp_ov = exp_ov | exp_sum[CW];
			end
			exp_inc = inc_f();
			exp_hit = exp_inc != 0;
		end
	end
	always @(negedge clk) begin
		if (!rst) begin
			check("hit_r", hit_r, exp_hit);
			check("count_r", count_r, exp_sum[CW-1:0]);
			check("overflow_r", overflow_r, exp_ov);
		end
	end
	initial begin
		rst = 1;
		sel = '0;
		count_en = 0;
		count_clear = 0;
		lfsr = 32'h32d6632b;
		rnd = lfsr;
		repeat (16) @(posedge clk);
		rst <= 0;
		for (int r = 0; r < 4; r++) begin
			// A second reset in mid-run must clear count and flag alike
			if (r == 2) begin
				rst <= 1;
				@(posedge clk);
				rst <= 0;
			end
			for (int e = 0; e < 8; e++) begin
				for (int k = 0; k < 8; k++) begin
					sel <= {ev_tab[e], (k < 7 ? 8'h01 << k : um_tab[r]), 4'h1 << r};
					repeat (30) begin
						@(posedge clk);
						lfsr = lfsr_f(lfsr);
						rnd <= lfsr;
						count_en <= |lfsr[2:0];
						count_clear <= lfsr[15:8] == 8'h00;
					end
				end
			end
		end
		repeat (3) @(posedge clk);
		close_out();
	end
	initial begin
		#(20 * 20000);
		bad_count++;
		close_out();
	end
endmodule : ucesd_tb_top
